// ===== core/cpw_cfg.svh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef CPW_CFG_SVH
`define CPW_CFG_SVH

`define CPW_OFS_FLAGS      12'h000
`define CPW_OFS_ENABLES    12'h004
`define CPW_OFS_PRIORITY   12'h008
`define CPW_OFS_TIMER      12'h00c
`define CPW_OFS_LIMIT      12'h010
`define CPW_OFS_TCTRL      12'h014
`define CPW_OFS_U1_PEND    12'h018
`define CPW_OFS_U1_ACT     12'h01c
`define CPW_OFS_U1_CTRL    12'h020
`define CPW_OFS_U2_PEND    12'h024
`define CPW_OFS_U2_ACT     12'h028
`define CPW_OFS_U2_CTRL    12'h02c
`define CPW_OFS_PWR        12'h030
`define CPW_OFS_DIR        12'h034

`define CPW_FLAG_MATCH_BIT 1
`define CPW_TC_RUN_BIT     2
`define CPW_TC_OUTPS_MASK  8'h7f
`define CPW_CTRL_MODE_PWM  4'hc
`define CPW_U2_CTRL_MASK   8'h3f
`define CPW_PWR_SLEEP_BIT  0
`define CPW_PWR_IDLE_BIT   1
`define CPW_DIR_RESET      8'h03
`define CPW_LIMIT_RESET    8'hff
`define CPW_OSC_PER_INC    4

`endif

// ===== core/cpw_pkg.sv
// Purpose: Types shared by the PWM timer block
// Assumes: Constants come from cpw_cfg.svh
// Notes:   Prescale encodings follow the timer control field
package cpw_pkg;

    typedef enum logic [1:0] {
        CPW_PS_1  = 2'h0,
        CPW_PS_4  = 2'h1,
        CPW_PS_16 = 2'h2,
        CPW_PS_16B = 2'h3
    } cpw_prescale_t;

    typedef enum logic [1:0] {
        CPW_APB_IDLE,
        CPW_APB_ACCESS
    } cpw_apb_st_t;

endpackage

// ===== core/cpw_prescaler.sv
// Purpose: Period timer prescaler and 2-bit sub-count for the time base
// Assumes: run_i is high while the timer runs; clk_i is the oscillator
// Notes:   Sub-count is the oscillator phase at 1:1, prescaler bits else
`timescale 1ns/1ps
module cpw_prescaler (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  run_i,
    input  wire logic                  clear_i,
    input  wire cpw_pkg::cpw_prescale_t sel_i,
    output logic                       inc_o,
    output logic [1:0]                 sub_o
);
    typedef struct packed {
        logic [1:0] phase;
        logic [3:0] pre;
    } cpw_ps_st_t;

    cpw_ps_st_t s_q;
    cpw_ps_st_t s_d;

    always_comb begin
        s_d   = s_q;
        inc_o = 1'b0;
        sub_o = 2'h0;
        if (clear_i) begin
            s_d = '0;
        end else if (run_i) begin
            s_d.phase = s_q.phase + 2'h1;
            if (s_q.phase == 2'h3) begin
                case (sel_i)
                    cpw_pkg::CPW_PS_1: begin
                        inc_o = 1'b1;
                    end
                    cpw_pkg::CPW_PS_4: begin
                        s_d.pre = {2'h0, s_q.pre[1:0] + 2'h1};
                        inc_o   = (s_q.pre[1:0] == 2'h3);
                    end
                    default: begin
                        s_d.pre = s_q.pre + 4'h1;
                        inc_o   = (s_q.pre == 4'hf);
                    end
                endcase
            end
        end
        // Low time-base bits of the next cycle; at 1:1 the clock phase.
        // Leading by a cycle lets the registered pin fall on time.
        case (sel_i)
            cpw_pkg::CPW_PS_1: sub_o = s_d.phase;
            cpw_pkg::CPW_PS_4: sub_o = s_d.pre[1:0];
            default:           sub_o = s_d.pre[3:2];
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== core/cpw_unit.sv
// Purpose: One PWM channel: duty double buffer and output compare
// Assumes: Period start and next-cycle time base from the shared timer
// Notes:   Output is forced low whenever the unit is not in PWM mode
`timescale 1ns/1ps
module cpw_unit (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       hold_i,
    input  wire logic       pwm_en_i,
    input  wire logic       start_i,
    input  wire logic [9:0] base_i,
    input  wire logic [7:0] pend_high_i,
    input  wire logic [1:0] low_bits_i,
    output logic [7:0]      act_high_o,
    output logic            pwm_o
);
    typedef struct packed {
        logic [7:0] act_high;
        logic [1:0] act_low;
        logic       out;
    } cpw_unit_st_t;

    cpw_unit_st_t s_q;
    cpw_unit_st_t s_d;
    logic [9:0]   new_duty;

    always_comb begin
        s_d      = s_q;
        new_duty = {pend_high_i, low_bits_i};
        if (!pwm_en_i) begin
            s_d.out = 1'b0;
        end else if (!hold_i) begin
            if (start_i) begin
                s_d.act_high = pend_high_i;
                s_d.act_low  = low_bits_i;
                s_d.out      = (new_duty != 10'h000);
            end else if (base_i == {s_q.act_high, s_q.act_low}) begin
                // A duty past the period never matches: pin stays put
                s_d.out = 1'b0;
            end
        end
    end

    assign act_high_o = s_q.act_high;
    assign pwm_o      = s_q.out;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== core/cpw_top.sv
// Purpose: PWM mode of two capture/compare/PWM units on a period timer
// Assumes: APB slave, 25 MHz clk_i as the oscillator, sync reset
// Notes:   Capture, compare, steering and shutdown are not built
//
// How it works
// - Period is (limit+1)*4 clocks*prescale
// - Match: clear timer, set pin, load duty
// - Zero duty never sets the pin
// - Postscaler plays no part in period
// - Duty is pending byte plus two bits
// - Duty writes take effect next period
// - Active duty register ignores writes
// - High time is duty*clock*prescale
// - Active duty double buffered with latch
// - Ten-bit base: timer plus two bits
// - Base equal active duty clears pin
// - Duty beyond period leaves pin unchanged
// - Sleep freezes timer, duty state and the pin of a unit in PWM mode
// - Idle keeps primary clock running logic
// - Reset: pins input, registers to reset
// - Prescale choices are 1, 4, 16
// - Full resolution only at limit 255
// - Timer match sets period flag
// - Cleared control releases pin to port
`timescale 1ns/1ps
`include "cpw_cfg.svh"
module cpw_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [1:0]  port_latch_i,
    output logic [1:0]       pwm_output_pin_o,
    output logic [1:0]       pwm_output_pin_oe_o,
    output logic             period_match_flag_o
);
    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [7:0]  priority_r;
        logic [7:0]  period_timer;
        logic [7:0]  period_limit;
        logic [7:0]  tctrl;
        logic [7:0]  pend1;
        logic [7:0]  ctrl1;
        logic [7:0]  pend2;
        logic [7:0]  ctrl2;
        logic [1:0]  pwr;
        logic [7:0]  dir;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [1:0]  pin;
        logic [1:0]  pin_oe;
    } cpw_top_st_t;

    cpw_top_st_t s_q;
    cpw_top_st_t s_d;

    logic                   sleep;
    logic                   run;
    logic                   inc;
    logic [1:0]             sub;
    logic                   start;
    logic [9:0]             base;
    logic                   pwm1_en;
    logic                   pwm2_en;
    logic [7:0]             act1;
    logic [7:0]             act2;
    logic                   pwm1;
    logic                   pwm2;
    logic                   wr_go;
    logic                   rd_go;
    logic [7:0]             wb;
    cpw_pkg::cpw_prescale_t ps_sel;

    assign sleep  = s_q.pwr[`CPW_PWR_SLEEP_BIT];
    // Idle keeps this clock running, so of the two power modes only sleep freezes the timer
    assign run    = s_q.tctrl[`CPW_TC_RUN_BIT] && !sleep;
    assign ps_sel = cpw_pkg::cpw_prescale_t'(s_q.tctrl[1:0]);
    assign start  = inc && (s_q.period_timer == s_q.period_limit);
    // Base of the next cycle: the duty match lands on the pin in the
    // cycle the base reaches it, so high time is exactly duty counts
    assign base   = {s_d.period_timer, sub};
    assign pwm1_en = (s_q.ctrl1[3:0] == `CPW_CTRL_MODE_PWM);
    assign pwm2_en = (s_q.ctrl2[3:0] == `CPW_CTRL_MODE_PWM);
    assign wr_go  = psel_i && penable_i && pwrite_i && !s_q.ready;
    assign rd_go  = psel_i && penable_i && !pwrite_i && !s_q.ready;
    assign wb     = pwdata_i[7:0];

    cpw_prescaler u_pre (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .run_i (run),
        .clear_i (1'b0),
        .sel_i (ps_sel),
        .inc_o (inc),
        .sub_o (sub)
    );

    cpw_unit u_unit1 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .hold_i      (!run),
        .pwm_en_i    (pwm1_en),
        .start_i     (start),
        .base_i      (base),
        .pend_high_i (s_q.pend1),
        .low_bits_i  (s_q.ctrl1[5:4]),
        .act_high_o  (act1),
        .pwm_o       (pwm1)
    );

    cpw_unit u_unit2 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .hold_i      (!run),
        .pwm_en_i    (pwm2_en),
        .start_i     (start),
        .base_i      (base),
        .pend_high_i (s_q.pend2),
        .low_bits_i  (s_q.ctrl2[5:4]),
        .act_high_o  (act2),
        .pwm_o       (pwm2)
    );

    always_comb begin
        s_d        = s_q;
        s_d.ready  = 1'b0;
        s_d.slverr = 1'b0;

        // Period timer: clears on the increment after the match
        if (inc) begin
            if (start) begin
                s_d.period_timer = 8'h00;
            end else begin
                s_d.period_timer = s_q.period_timer + 8'h01;
            end
        end

        // APB: one wait state, answer in the second access cycle
        if (wr_go || rd_go) begin
            s_d.ready = 1'b1;
        end
        if (wr_go && pstrb_i[0]) begin
            case (paddr_i)
                `CPW_OFS_FLAGS:    s_d.flags      = wb;
                `CPW_OFS_ENABLES:  s_d.enables    = wb;
                `CPW_OFS_PRIORITY: s_d.priority_r = wb;
                `CPW_OFS_TIMER:    s_d.period_timer = wb;
                `CPW_OFS_LIMIT:    s_d.period_limit = wb;
                `CPW_OFS_TCTRL:
                    s_d.tctrl = wb & `CPW_TC_OUTPS_MASK;
                `CPW_OFS_U1_PEND:  s_d.pend1 = wb;
                `CPW_OFS_U1_CTRL:  s_d.ctrl1 = wb;
                `CPW_OFS_U2_PEND:  s_d.pend2 = wb;
                `CPW_OFS_U2_CTRL:
                    s_d.ctrl2 = wb & `CPW_U2_CTRL_MASK;
                `CPW_OFS_PWR:      s_d.pwr = wb[1:0];
                `CPW_OFS_DIR:      s_d.dir = wb;
                `CPW_OFS_U1_ACT,
                `CPW_OFS_U2_ACT: begin
                    // Active duty is loaded by hardware only
                    s_d.slverr = 1'b0;
                end
                default: s_d.slverr = 1'b1;
            endcase
        end else if (wr_go) begin
            s_d.slverr = 1'b0;
        end

        // Set beats a software clear in the same cycle
        if (start) begin
            s_d.flags[`CPW_FLAG_MATCH_BIT] = 1'b1;
        end

        if (rd_go) begin
            s_d.rdata = 32'h0000_0000;
            case (paddr_i)
                `CPW_OFS_FLAGS:    s_d.rdata[7:0] = s_q.flags;
                `CPW_OFS_ENABLES:  s_d.rdata[7:0] = s_q.enables;
                `CPW_OFS_PRIORITY: s_d.rdata[7:0] = s_q.priority_r;
                `CPW_OFS_TIMER:    s_d.rdata[7:0] = s_q.period_timer;
                `CPW_OFS_LIMIT:    s_d.rdata[7:0] = s_q.period_limit;
                `CPW_OFS_TCTRL:    s_d.rdata[7:0] = s_q.tctrl;
                `CPW_OFS_U1_PEND:  s_d.rdata[7:0] = s_q.pend1;
                `CPW_OFS_U1_ACT:   s_d.rdata[7:0] = act1;
                `CPW_OFS_U1_CTRL:  s_d.rdata[7:0] = s_q.ctrl1;
                `CPW_OFS_U2_PEND:  s_d.rdata[7:0] = s_q.pend2;
                `CPW_OFS_U2_ACT:   s_d.rdata[7:0] = act2;
                `CPW_OFS_U2_CTRL:  s_d.rdata[7:0] = s_q.ctrl2;
                `CPW_OFS_PWR:      s_d.rdata[1:0] = s_q.pwr;
                `CPW_OFS_DIR:      s_d.rdata[7:0] = s_q.dir;
                default:           s_d.slverr = 1'b1;
            endcase
        end

        // Pin mux: PWM drives only in PWM mode, else the port latch.
        // Output enable is the inverse of the direction bit kept by software.
        s_d.pin[0] = pwm1_en ? pwm1 : port_latch_i[0];
        s_d.pin[1] = pwm2_en ? pwm2 : port_latch_i[1];
        s_d.pin_oe = ~s_q.dir[1:0];
    end

    assign prdata_o            = s_q.rdata;
    assign pready_o            = s_q.ready;
    assign pslverr_o           = s_q.slverr;
    assign pwm_output_pin_o    = s_q.pin;
    assign pwm_output_pin_oe_o = s_q.pin_oe;
    assign period_match_flag_o = s_q.flags[`CPW_FLAG_MATCH_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q              <= '0;
            s_q.period_limit <= `CPW_LIMIT_RESET;
            s_q.dir          <= `CPW_DIR_RESET;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ===== testbench/cpw_top_props.sv
// Purpose: Port assertions for cpw_top
// Assumes: Register writes are decoded here from the APB pins
// Notes:   Pin checks give the registered output two cycles to settle
`timescale 1ns/1ps
`include "cpw_cfg.svh"
module cpw_top_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [1:0]  port_latch_i,
    input wire logic [1:0]  pwm_output_pin_o,
    input wire logic [1:0]  pwm_output_pin_oe_o,
    input wire logic        period_match_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       wr, pwm_q, slp_q, run_q, fw_q;
    logic [1:0] dir_q;
    assign wr = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0];
    always_ff @(posedge clk_i) begin
        // The register takes the write at the same edge that pready rises
        fw_q <= psel_i && penable_i && pwrite_i && pstrb_i[0]
            && paddr_i == `CPW_OFS_FLAGS;
        if (rst_i)
            {dir_q, pwm_q, slp_q, run_q} <= 5'h18;
        else if (wr && paddr_i == `CPW_OFS_DIR)
            dir_q <= pwdata_i[1:0];
        else if (wr && paddr_i == `CPW_OFS_U1_CTRL)
            pwm_q <= pwdata_i[3:0] == `CPW_CTRL_MODE_PWM;
        else if (wr && paddr_i == `CPW_OFS_TCTRL)
            run_q <= pwdata_i[`CPW_TC_RUN_BIT];
        else if (wr && paddr_i == `CPW_OFS_PWR)
            slp_q <= pwdata_i[`CPW_PWR_SLEEP_BIT];
    end
    a_ready_answer: assert property (psel_i && penable_i && !pready_o
        |=> pready_o) else $error("access not answered");
    a_err_unmapped: assert property (psel_i && penable_i && !pready_o
        && paddr_i > `CPW_OFS_DIR |=> pslverr_o) else $error("no error");
    a_reset_out: assert property (disable iff (1'b0) rst_i |=>
        pwm_output_pin_oe_o == 2'h0 && pwm_output_pin_o == 2'h0
        && !period_match_flag_o) else $error("outputs not reset");
    a_oe_dir: assert property (dir_q == $past(dir_q)
        |-> pwm_output_pin_oe_o == ~dir_q) else $error("enable wrong");
    // Mode and latch must be settled two cycles, the pin is registered
    a_port_pass: assert property (!pwm_q && !$past(pwm_q)
        && !$past(pwm_q, 2) && !slp_q && !$past(slp_q, 2)
        && port_latch_i[0] == $past(port_latch_i[0])
        && port_latch_i[0] == $past(port_latch_i[0], 2)
        |-> pwm_output_pin_o[0] == port_latch_i[0])
        else $error("pin does not follow port latch");
    a_sleep_freeze: assert property (slp_q && $past(slp_q)
        && $past(slp_q, 2) |-> $stable(pwm_output_pin_o))
        else $error("pin moved while asleep");
    a_flag_fall: assert property ($fell(period_match_flag_o)
        |-> fw_q || $past(fw_q)) else $error("flag cleared unasked");
    a_flag_rise: assert property ($rose(period_match_flag_o)
        |-> run_q || $past(run_q, 2) || fw_q || $past(fw_q))
        else $error("flag set while timer stopped");
    c_pulse: cover property ($rose(pwm_output_pin_o[0]));
    c_error: cover property (pslverr_o);
    c_match: cover property ($rose(period_match_flag_o));
endmodule

bind cpw_top cpw_top_props cpw_top_props_inst (.*);

// ===== testbench/cpw_load.sv
// Purpose: Load on one PWM pin; times its pulses in clk_i cycles
// Assumes: Pin has a pull-down, so an undriven pin reads low
// Notes:   Width and period are those of the last complete pulse
`timescale 1ns/1ps
module cpw_load (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   pin_i,
    input  wire logic   oe_i,
    output logic        level_o,
    output logic [31:0] rises_o,
    output logic [31:0] high_o,
    output logic [31:0] period_o
);
    logic        last_q;
    logic [31:0] cnt_q;
    // Waveform reaches the load only while the driver is enabled
    assign level_o = oe_i ? pin_i : 1'b0;
    always_ff @(posedge clk_i) begin
        last_q <= level_o;
        cnt_q <= level_o && !last_q ? 32'h1 : cnt_q + 32'h1;
        if (rst_i)
            rises_o <= 32'h0;
        else if (level_o && !last_q)
            rises_o <= rises_o + 32'h1;
        if (level_o && !last_q)
            period_o <= cnt_q;
        if (!level_o && last_q)
            high_o <= cnt_q;
    end
endmodule

// ===== testbench/cpw_top_tb_top.sv
// Purpose: Register-level tests of cpw_top over APB
// Assumes: 25 MHz clock, sync reset held five cycles
// Notes:   Pulse and period are measured by the load model
`timescale 1ns/1ps
`include "cpw_cfg.svh"
module cpw_top_tb_top;
    logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o;
    logic        pslverr_o, period_match_flag_o, lvl, err;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rises, hi, per, rd, t, cyc;
    logic [31:0] fails, total_checks;
    logic [3:0]  pstrb_i;
    logic [1:0]  port_latch_i, pin, oe;
    logic [7:0]  lim [4] = '{8'h09, 8'h09, 8'h09, 8'hff};
    logic [1:0]  ps  [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [9:0]  dut [4] = '{10'h00d, 10'h021, 10'h027, 10'h3fd};
    int          mul [4] = '{4, 16, 16, 1};
    cpw_top cpw_top_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_output_pin_o(pin),
        .port_latch_i(port_latch_i), .pwm_output_pin_oe_o(oe),
        .period_match_flag_o(period_match_flag_o));
    cpw_load cpw_load_inst (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin[0]),
        .oe_i(oe[0]), .level_o(lvl), .rises_o(rises), .high_o(hi),
        .period_o(per));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        {psel_i, penable_i, pwrite_i} <= {2'b10, w};
        {paddr_i, pwdata_i, pstrb_i} <= {a, d, s};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1);
        {rd, err} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
        check("answer cycles", n, 32'd2);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask
    task automatic wait_rises(input int n);
        logic [31:0] g;
        g = rises + n;
        for (int k = 0; rises < g && k < 30000; k++)
            @(posedge clk_i);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Longest case is three periods at limit 255 and prescale 1, far below this
    always @(posedge clk_i) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd60000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i} = 4'h8;
        {paddr_i, pwdata_i, pstrb_i, port_latch_i, cyc} = '0;
        {fails, total_checks} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= `CPW_OFS_DIR; a += 4) begin
            t = a == `CPW_OFS_LIMIT ? `CPW_LIMIT_RESET : 32'h0;
            if (a == `CPW_OFS_DIR)
                t = `CPW_DIR_RESET;
            rdc(a[11:0], t);
        end
        apb(1'b0, 12'h038, 32'h0, 4'h0);
        check("slverr", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h03c, 32'h0, 4'h1);
        check("wr slverr", {31'h0, err}, 32'h1);
        wr(`CPW_OFS_LIMIT, 32'h9);
        wr(`CPW_OFS_U1_CTRL, 32'h1c);
        wr(`CPW_OFS_U1_PEND, 32'h3);
        wr(`CPW_OFS_TCTRL, 32'h7c);
        repeat (60) @(posedge clk_i);
        rdc(`CPW_OFS_FLAGS, 32'h2);
        rdc(`CPW_OFS_U1_ACT, 32'h3);
        wr(`CPW_OFS_DIR, 32'h0);
        wait_rises(3);
        check("period", per, 32'd40);
        check("high", hi, 32'd13);
        wr(`CPW_OFS_U1_ACT, 32'haa);
        apb(1'b1, `CPW_OFS_U1_PEND, 32'hee, 4'h0);
        rdc(`CPW_OFS_U1_ACT, 32'h3);
        rdc(`CPW_OFS_U1_PEND, 32'h3);
        wait_rises(1);
        wr(`CPW_OFS_U1_PEND, 32'h7);
        rdc(`CPW_OFS_U1_ACT, 32'h3);
        wait_rises(1);
        rdc(`CPW_OFS_U1_ACT, 32'h7);
        wr(`CPW_OFS_U1_PEND, 32'h0);
        wr(`CPW_OFS_U1_CTRL, 32'h0c);
        // Two periods: the zero duty is loaded at the next start
        repeat (80) @(posedge clk_i);
        t = rises;
        repeat (200) @(posedge clk_i);
        check("zero duty", rises, t);
        wr(`CPW_OFS_U1_PEND, 32'hff);
        repeat (200) @(posedge clk_i);
        check("long duty", {31'h0, lvl}, 32'h1);
        wr(`CPW_OFS_PWR, 32'h1);
        wr(`CPW_OFS_FLAGS, 32'h0);
        apb(1'b0, `CPW_OFS_TIMER, 32'h0, 4'h0);
        t = rd;
        repeat (100) @(posedge clk_i);
        rdc(`CPW_OFS_TIMER, t);
        wr(`CPW_OFS_PWR, 32'h2);
        repeat (60) @(posedge clk_i);
        rdc(`CPW_OFS_FLAGS, 32'h2);
        check("flag out", {31'h0, period_match_flag_o}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(`CPW_OFS_LIMIT, {24'h0, lim[i]});
            wr(`CPW_OFS_U1_PEND, {24'h0, dut[i][9:2]});
            wr(`CPW_OFS_U1_CTRL, {26'h0, dut[i][1:0], 4'hc});
            wr(`CPW_OFS_TCTRL, {30'h1, ps[i]});
            wait_rises(3);
            t = (lim[i] + 32'h1) * 4 * mul[i];
            check("period", per, t);
            check("high", hi, dut[i] * mul[i]);
        end
        wr(`CPW_OFS_U2_PEND, 32'h5a);
        wr(`CPW_OFS_U2_CTRL, 32'hfc);
        rdc(`CPW_OFS_U2_CTRL, 32'h3c);
        wait_rises(1);
        rdc(`CPW_OFS_U2_ACT, 32'h5a);
        wr(`CPW_OFS_U2_CTRL, 32'h08);
        wr(`CPW_OFS_U1_CTRL, 32'h08);
        port_latch_i <= 2'h3;
        repeat (4) @(posedge clk_i);
        check("latch pin", {30'h0, pin}, 32'h3);
        wr(`CPW_OFS_DIR, 32'h3);
        repeat (3) @(posedge clk_i);
        check("pin enable", {30'h0, oe}, 32'h0);
        wrap_up();
    end
endmodule
